//--- rtl/cmpsc_top.sv
// clock mode selection and sleep/stop power saving control, apb slave
// assumes i_bit_tick is the stabilisation prescaler tick and wake inputs are synchronous
module cmpsc_top
(
    // clock and reset
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_rstn,
    // apb slave
    input  wire logic                           i_psel,
    input  wire logic                           i_penable,
    input  wire logic                           i_pwrite,
    input  wire logic [7:0]                     i_paddr,
    input  wire logic [31:0]                    i_pwdata,
    output logic                                o_pready,
    output logic                                o_pslverr,
    output logic [31:0]                         o_prdata,
    // cpu side
    input  wire logic                           i_stop_instr,
    input  wire logic                           i_global_int_en,
    input  wire logic                           i_irq_any,
    input  wire logic [cmpsc_pkg::WAKE_SRC_W-1:0] i_stop_wake_src,
    input  wire logic                           i_bit_tick,
    // clock gating
    output logic                                o_cpu_clk_en,
    output logic                                o_periph_clk_en,
    output logic                                o_main_osc_en,
    output logic                                o_sub_clk_sel,
    output logic                                o_pc_hold,
    // peripheral run enables
    output logic                                o_bit_run,
    output logic                                o_wdt_run,
    output logic                                o_watch_run,
    output logic                                o_timer_run,
    // wake outcome pulses
    output logic                                o_wake_vector,
    output logic                                o_wake_resume
);
    cmpsc_pkg::cmpsc_state_t st_reg;
    cmpsc_pkg::cmpsc_state_t st_next;

    logic       acc_phase;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wbyte;
    logic       stop_wake;
    logic       rc_osc_watchdog;
    logic       main_osc_ok;
    logic       evmode;
    logic       wsub;

    // pready is registered, so every access sees one wait state
    assign acc_phase = i_psel && i_penable && !st_reg.rsp.pready;
    assign wr_en     = acc_phase && i_pwrite;
    assign rd_en     = acc_phase && !i_pwrite;
    assign wbyte     = i_pwdata[7:0];
    assign stop_wake = |i_stop_wake_src;
    assign rc_osc_watchdog = st_reg.control[cmpsc_pkg::CTL_RC_OSC_WATCHDOG_BIT];
    assign evmode    = st_reg.control[cmpsc_pkg::CTL_EVENT_BIT];
    assign wsub      = st_reg.control[cmpsc_pkg::CTL_WSUB_BIT];

    always_comb
    begin
        st_next                  = st_reg;
        // wake pulses last a single cycle
        st_next.gate.wake_vector = 1'b0;
        st_next.gate.wake_resume = 1'b0;
        st_next.rsp.pready       = acc_phase;
        st_next.rsp.pslverr      = 1'b0;
        st_next.rsp.prdata       = 32'h0000_0000;

        // register writes; mode follows the written clock code
        // a write commits on the first access edge, apb cannot abort it
        if (wr_en)
        begin
            case (i_paddr)
                cmpsc_pkg::ADDR_CLK_MODE:
                begin
                    st_next.clk_mode = wbyte;
                    case (st_reg.mode)
                        cmpsc_pkg::CMPSC_MAIN:
                        begin
                            if (wbyte == cmpsc_pkg::SCM_TO_SUB1)
                            begin
                                st_next.mode = cmpsc_pkg::CMPSC_SUB1;
                            end
                            else if (wbyte == cmpsc_pkg::SCM_TO_SUB2)
                            begin
                                st_next.mode = cmpsc_pkg::CMPSC_SUB2;
                            end
                        end
                        cmpsc_pkg::CMPSC_SUB1:
                        begin
                            if (wbyte == cmpsc_pkg::SCM_TO_MAIN)
                            begin
                                st_next.mode = cmpsc_pkg::CMPSC_MAIN;
                            end
                            else if (wbyte[cmpsc_pkg::SCM_SUB2_BIT])
                            begin
                                st_next.mode = cmpsc_pkg::CMPSC_SUB2;
                            end
                        end
                        cmpsc_pkg::CMPSC_SUB2:
                        begin
                            if (!wbyte[cmpsc_pkg::SCM_SUB2_BIT])
                            begin
                                st_next.mode = cmpsc_pkg::CMPSC_SUB1;
                            end
                        end
                        default:
                        begin
                            st_next.mode = cmpsc_pkg::CMPSC_MAIN;
                        end
                    endcase
                end
                cmpsc_pkg::ADDR_SLEEP_STOP:
                begin
                    // only the two select codes are stored
                    if (wbyte == cmpsc_pkg::SSC_SLEEP)
                    begin
                        st_next.sleep_stop = wbyte;
                        st_next.stop_armed = 1'b0;
                        st_next.pwr        = cmpsc_pkg::CMPSC_SLEEP;
                    end
                    else if (wbyte == cmpsc_pkg::SSC_STOP)
                    begin
                        st_next.sleep_stop = wbyte;
                        st_next.stop_armed = 1'b1;
                    end
                    // any other code leaves state untouched
                end
                cmpsc_pkg::ADDR_CONTROL:
                begin
                    // control bits choose which timers survive stop
                    st_next.control = i_pwdata[2:0];
                end
                cmpsc_pkg::ADDR_STATUS:
                begin
                    // status is read-only
                    st_next.rsp.pslverr = acc_phase;
                end
                default:
                begin
                    st_next.rsp.pslverr = acc_phase;
                end
            endcase
        end

        // register reads
        if (rd_en)
        begin
            case (i_paddr)
                cmpsc_pkg::ADDR_CLK_MODE:
                begin
                    st_next.rsp.prdata = {24'h00_0000, st_reg.clk_mode};
                end
                cmpsc_pkg::ADDR_SLEEP_STOP:
                begin
                    st_next.rsp.prdata = {24'h00_0000, st_reg.sleep_stop};
                end
                cmpsc_pkg::ADDR_STATUS:
                begin
                    st_next.rsp.prdata = {16'h0000,
                                          st_reg.bit_cnt,
                                          3'h0,
                                          st_reg.stop_armed,
                                          st_reg.pwr,
                                          st_reg.mode};
                end
                cmpsc_pkg::ADDR_CONTROL:
                begin
                    st_next.rsp.prdata = {29'h0000_0000, st_reg.control};
                end
                default:
                begin
                    // reads of unmapped addresses fail too
                    st_next.rsp.pslverr = 1'b1;
                end
            endcase
        end

        // power state sequence
        case (st_reg.pwr)
            cmpsc_pkg::CMPSC_RUN:
            begin
                // stop outranks a sleep write in the same cycle
                if (i_stop_instr && st_reg.stop_armed)
                begin
                    st_next.pwr        = cmpsc_pkg::CMPSC_STOP;
                    st_next.stop_armed = 1'b0;
                end
            end
            cmpsc_pkg::CMPSC_SLEEP:
            begin
                if (i_irq_any)
                begin
                    // registers kept, only the select code is spent
                    st_next.pwr              = cmpsc_pkg::CMPSC_RUN;
                    st_next.sleep_stop       = cmpsc_pkg::SSC_RESET;
                    st_next.gate.wake_vector = i_global_int_en;
                    st_next.gate.wake_resume = !i_global_int_en;
                end
            end
            cmpsc_pkg::CMPSC_STOP:
            begin
                // outside sub2 mode the main oscillator restarts before the cpu clock
                if (stop_wake)
                begin
                    st_next.pwr        = cmpsc_pkg::CMPSC_WARM;
                    st_next.bit_cnt    = cmpsc_pkg::BIT_START;
                    st_next.sleep_stop = cmpsc_pkg::SSC_RESET;
                end
            end
            cmpsc_pkg::CMPSC_WARM:
            begin
                if (i_bit_tick)
                begin
                    st_next.bit_cnt = st_reg.bit_cnt + 8'h01;
                    // overflow of the count ends warm-up
                    if (st_reg.bit_cnt == cmpsc_pkg::BIT_LAST)
                    begin
                        st_next.pwr              = cmpsc_pkg::CMPSC_RUN;
                        st_next.gate.wake_vector = i_global_int_en;
                        st_next.gate.wake_resume = !i_global_int_en;
                    end
                end
            end
            default:
            begin
                st_next.pwr = cmpsc_pkg::CMPSC_RUN;
            end
        endcase

        // clock gates and run enables from the next state
        main_osc_ok = !((st_next.mode == cmpsc_pkg::CMPSC_SUB2) &&
                        st_next.clk_mode[cmpsc_pkg::SCM_SUB2_BIT]);
        st_next.gate.sub_clk_sel = (st_next.mode != cmpsc_pkg::CMPSC_MAIN);
        case (st_next.pwr)
            cmpsc_pkg::CMPSC_RUN:
            begin
                // cpu keeps its clock whichever source is selected
                st_next.gate.cpu_clk_en    = 1'b1;
                st_next.gate.periph_clk_en = 1'b1;
                st_next.gate.main_osc_en   = main_osc_ok;
                st_next.gate.pc_hold       = 1'b0;
                st_next.gate.bit_run       = 1'b1;
                st_next.gate.wdt_run       = 1'b1;
                st_next.gate.watch_run     = 1'b1;
                st_next.gate.timer_run     = 1'b1;
            end

            cmpsc_pkg::CMPSC_SLEEP:
            begin
                // the cpu loses its clock, the watchdog and watch timer stop
                st_next.gate.cpu_clk_en    = 1'b0;
                st_next.gate.periph_clk_en = 1'b1;
                st_next.gate.main_osc_en   = main_osc_ok;
                st_next.gate.pc_hold       = 1'b1;
                st_next.gate.bit_run       = 1'b1;
                st_next.gate.wdt_run       = 1'b0;
                st_next.gate.watch_run     = 1'b0;
                st_next.gate.timer_run     = 1'b1;
            end

            cmpsc_pkg::CMPSC_STOP:
            begin
                // only sub or rc clocked blocks may keep running
                st_next.gate.cpu_clk_en    = 1'b0;
                st_next.gate.periph_clk_en = 1'b0;
                st_next.gate.main_osc_en   = 1'b0;
                st_next.gate.pc_hold       = 1'b1;
                st_next.gate.bit_run       = rc_osc_watchdog;
                st_next.gate.wdt_run       = rc_osc_watchdog;
                st_next.gate.watch_run     = wsub;
                st_next.gate.timer_run     = evmode;
            end

            cmpsc_pkg::CMPSC_WARM:
            begin
                // oscillator settles, only the interval timer counts
                st_next.gate.cpu_clk_en    = 1'b0;
                st_next.gate.periph_clk_en = 1'b0;
                st_next.gate.main_osc_en   = main_osc_ok;
                st_next.gate.pc_hold       = 1'b1;
                st_next.gate.bit_run       = 1'b1;
                st_next.gate.wdt_run       = 1'b0;
                st_next.gate.watch_run     = 1'b0;
                st_next.gate.timer_run     = 1'b0;
            end

            default:
            begin
                st_next.gate.cpu_clk_en    = 1'b1;
                st_next.gate.periph_clk_en = 1'b1;
                st_next.gate.main_osc_en   = main_osc_ok;
                st_next.gate.pc_hold       = 1'b0;
                st_next.gate.bit_run       = 1'b1;
                st_next.gate.wdt_run       = 1'b1;
                st_next.gate.watch_run     = 1'b1;
                st_next.gate.timer_run     = 1'b1;
            end
        endcase
    end

    // reset returns every gate to main active run
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_reg            <= '0;
            st_reg.mode       <= cmpsc_pkg::CMPSC_MAIN;
            st_reg.pwr        <= cmpsc_pkg::CMPSC_RUN;
            st_reg.clk_mode   <= cmpsc_pkg::SCM_RESET;
            st_reg.sleep_stop <= cmpsc_pkg::SSC_RESET;
            st_reg.control    <= cmpsc_pkg::CTL_RESET;
            st_reg.bit_cnt    <= cmpsc_pkg::BIT_START;
            st_reg.gate.cpu_clk_en    <= 1'b1;
            st_reg.gate.periph_clk_en <= 1'b1;
            st_reg.gate.main_osc_en   <= 1'b1;
            st_reg.gate.sub_clk_sel   <= 1'b0;
            st_reg.gate.bit_run       <= 1'b1;
            st_reg.gate.wdt_run       <= 1'b1;
            st_reg.gate.watch_run     <= 1'b1;
            st_reg.gate.timer_run     <= 1'b1;
            st_reg.gate.pc_hold       <= 1'b0;
            st_reg.gate.wake_vector   <= 1'b0;
            st_reg.gate.wake_resume   <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign o_pready        = st_reg.rsp.pready;
    assign o_pslverr       = st_reg.rsp.pslverr;
    assign o_prdata        = st_reg.rsp.prdata;
    assign o_cpu_clk_en    = st_reg.gate.cpu_clk_en;
    assign o_periph_clk_en = st_reg.gate.periph_clk_en;
    assign o_main_osc_en   = st_reg.gate.main_osc_en;
    assign o_sub_clk_sel   = st_reg.gate.sub_clk_sel;
    assign o_pc_hold       = st_reg.gate.pc_hold;
    assign o_bit_run       = st_reg.gate.bit_run;
    assign o_wdt_run       = st_reg.gate.wdt_run;
    assign o_watch_run     = st_reg.gate.watch_run;
    assign o_timer_run     = st_reg.gate.timer_run;
    assign o_wake_vector   = st_reg.gate.wake_vector;
    assign o_wake_resume   = st_reg.gate.wake_resume;
endmodule

//--- rtl/cmpsc_pkg.sv
// constants and types for the clock mode and power saving controller
// assumes a 32-bit apb master and a cpu that reports its stop instruction
package cmpsc_pkg;
    // apb byte offsets
    localparam logic [7:0] ADDR_CLK_MODE   = 8'h00;
    localparam logic [7:0] ADDR_SLEEP_STOP = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_CONTROL    = 8'h0c;
    // clock mode register codes and fields
    localparam logic [7:0] SCM_RESET       = 8'h00;
    localparam logic [7:0] SCM_TO_SUB1     = 8'h02;
    localparam logic [7:0] SCM_TO_SUB2     = 8'h06;
    localparam logic [7:0] SCM_TO_MAIN     = 8'h01;
    localparam int         SCM_SUB2_BIT    = 2;
    // sleep/stop select codes
    localparam logic [7:0] SSC_RESET       = 8'h00;
    localparam logic [7:0] SSC_SLEEP       = 8'h0f;
    localparam logic [7:0] SSC_STOP        = 8'h5a;
    // control register fields
    localparam int         CTL_RC_OSC_WATCHDOG_BIT = 0;
    localparam int         CTL_EVENT_BIT   = 1;
    localparam int         CTL_WSUB_BIT    = 2;
    localparam logic [2:0] CTL_RESET       = 3'h0;
    // stabilisation counter and wake source width
    localparam logic [7:0] BIT_START       = 8'h00;
    localparam logic [7:0] BIT_LAST        = 8'hff;
    localparam int         WAKE_SRC_W      = 6;

    typedef enum logic [1:0] {CMPSC_MAIN, CMPSC_SUB1, CMPSC_SUB2} cmpsc_mode_t;
    typedef enum logic [1:0] {CMPSC_RUN, CMPSC_SLEEP, CMPSC_STOP, CMPSC_WARM} cmpsc_pwr_t;

    typedef struct packed {
        logic        cpu_clk_en;
        logic        periph_clk_en;
        logic        main_osc_en;
        logic        sub_clk_sel;
        logic        bit_run;
        logic        wdt_run;
        logic        watch_run;
        logic        timer_run;
        logic        pc_hold;
        logic        wake_vector;
        logic        wake_resume;
    } cmpsc_gate_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cmpsc_apb_rsp_t;

    typedef struct packed {
        cmpsc_mode_t    mode;
        cmpsc_pwr_t     pwr;
        logic [7:0]     clk_mode;
        logic [7:0]     sleep_stop;
        logic [2:0]     control;
        logic           stop_armed;
        logic [7:0]     bit_cnt;
        cmpsc_gate_t    gate;
        cmpsc_apb_rsp_t rsp;
    } cmpsc_state_t;
endpackage

//--- testbench/cmpsc_monitor.sv
// assertions on the ports of the clock mode and power saving controller
// bound into every cmpsc_top below; one clock domain, async active-low reset
module cmpsc_monitor
(
    // clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    // apb slave side
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    // cpu side
    input wire logic        i_stop_instr,
    input wire logic        i_global_int_en,
    input wire logic        i_irq_any,
    input wire logic [5:0]  i_stop_wake_src,
    input wire logic        i_bit_tick,
    // gates and pulses
    input wire logic        o_cpu_clk_en,
    input wire logic        o_periph_clk_en,
    input wire logic        o_main_osc_en,
    input wire logic        o_sub_clk_sel,
    input wire logic        o_pc_hold,
    input wire logic        o_bit_run,
    input wire logic        o_watch_run,
    input wire logic        o_timer_run,
    input wire logic        o_wake_vector,
    input wire logic        o_wake_resume
);
    logic       take, slp, stp, warm;
    logic [8:0] tick_cnt_reg;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    assign take = i_psel && i_penable && i_pwrite && !o_pready;
    assign slp  = !o_cpu_clk_en && o_periph_clk_en;
    assign stp  = !o_periph_clk_en && !o_main_osc_en;
    assign warm = !o_periph_clk_en && o_main_osc_en;

    // ticks seen while warming up
    always_ff @(posedge i_ref_clk or negedge i_rstn)
        if (!i_rstn)
            tick_cnt_reg <= 9'h000;
        else
            tick_cnt_reg <= warm ? tick_cnt_reg + {8'h00, i_bit_tick} : 9'h000;

    run_gate_a: assert property (o_cpu_clk_en |-> o_periph_clk_en && !o_pc_hold)
        else $error("cpu clock runs while held");
    main_osc_a: assert property (o_cpu_clk_en && !o_sub_clk_sel |-> o_main_osc_en)
        else $error("main clock selected without main oscillator");
    sleep_gate_a: assert property (slp |-> o_bit_run && o_timer_run && !o_watch_run && o_pc_hold)
        else $error("wrong run enables in sleep");
    stop_hold_a: assert property (stp |-> o_pc_hold && !o_cpu_clk_en)
        else $error("stop without pc hold");
    sleep_entry_a: assert property (take && i_paddr == 8'h04 && i_pwdata[7:0] == 8'h0f && o_cpu_clk_en
        |=> o_pready && !o_cpu_clk_en)
        else $error("sleep code did not stop cpu clock");
    bad_code_a: assert property (take && i_paddr == 8'h04 && i_pwdata[7:0] != 8'h0f && i_pwdata[7:0] != 8'h5a
        && o_cpu_clk_en && !i_stop_instr ##1 !i_stop_instr |=> o_cpu_clk_en)
        else $error("unknown select code changed power state");
    sub_entry_a: assert property (take && i_paddr == 8'h00 && i_pwdata[7:0] == 8'h02 && o_cpu_clk_en
        && !o_sub_clk_sel |=> o_cpu_clk_en ##1 (o_cpu_clk_en && o_sub_clk_sel))
        else $error("sub mode entry failed or paused cpu");
    sleep_wake_a: assert property (slp && i_irq_any |=> o_cpu_clk_en && o_wake_vector == $past(i_global_int_en)
        && o_wake_resume != $past(i_global_int_en))
        else $error("sleep wake missing or wrong pulse");
    stop_wake_a: assert property (stp && |i_stop_wake_src |=> warm)
        else $error("stop wake source ignored");
    warm_len_a: assert property ($rose(o_cpu_clk_en) && $past(warm) |-> tick_cnt_reg == 9'd256)
        else $error("warm-up length wrong");

    cover property (slp ##1 o_cpu_clk_en);
    cover property (warm ##1 o_cpu_clk_en);
    cover property (take && i_paddr == 8'h00 && i_pwdata[7:0] == 8'h02);
endmodule

bind cmpsc_top cmpsc_monitor u_cmpsc_monitor (.i_ref_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .i_stop_instr, .i_global_int_en, .i_irq_any, .i_stop_wake_src, .i_bit_tick,
    .o_cpu_clk_en, .o_periph_clk_en, .o_main_osc_en, .o_sub_clk_sel, .o_pc_hold, .o_bit_run, .o_watch_run,
    .o_timer_run, .o_wake_vector, .o_wake_resume);

//--- testbench/tb.sv
// self-checking bench for the clock mode and power saving controller
// drives apb and cpu side of cmpsc_top directly; expected apb answers queued
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn, psel, penable, pwrite, stop_instr, iflag, irq;
    logic        tick = 1'b0;
    logic        pready, pslverr, cpu, per, osc, sub, hold, bitr, wdt, watch, tmr, wvec, wres;
    logic [7:0]  paddr, code;
    logic [31:0] pwdata, prdata;
    logic [5:0]  src;
    logic [2:0]  ctl;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    int          err_count, check_count, n;
    localparam logic [7:0] TAB[7] = '{8'h02, 8'h06, 8'h02, 8'h01, 8'h06, 8'h02, 8'h01};
    localparam logic [4:0] GM[7]  = '{5'h1d, 5'h16, 5'h1d, 5'h18, 5'h16, 5'h1d, 5'h18};

    cmpsc_top u_cmpsc_top (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_prdata(prdata), .i_stop_instr(stop_instr), .i_global_int_en(iflag), .i_irq_any(irq),
        .i_stop_wake_src(src), .i_bit_tick(tick), .o_cpu_clk_en(cpu), .o_periph_clk_en(per),
        .o_main_osc_en(osc), .o_sub_clk_sel(sub), .o_pc_hold(hold), .o_bit_run(bitr), .o_wdt_run(wdt),
        .o_watch_run(watch), .o_timer_run(tmr), .o_wake_vector(wvec), .o_wake_resume(wres));

    always #10 clk = ~clk;
    always @(posedge clk) tick <= ~tick;

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
                       input logic [31:0] x);
        int k;
        k = 0;
        exp_q.push_back({wr, err, x});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_cpu(output int k);
        k = 0;
        while (cpu !== 1'b1 && k < 1000)
        begin
            @(posedge clk);
            k++;
        end
        if (cpu !== 1'b1)
            err_count++;
    endtask

    task automatic stop_pulse;
        stop_instr <= 1'b1;
        @(posedge clk);
        stop_instr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task finish_test;
        if (exp_q.size() != 0)
            err_count++;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if (pready === 1'b1 && exp_q.size() == 0)
            err_count++;
        else if (pready === 1'b1)
        begin
            e = exp_q.pop_front();
            `CHK(pslverr, e[32])
            if (!e[33])
                `CHK(prdata, e[31:0])
        end
    end

    initial
    begin
        #100000;
        err_count++;
        finish_test();
    end

    initial
    begin
        {rstn, psel, penable, pwrite, stop_instr, iflag, irq, paddr, pwdata, src} = '0;
        err_count = 0;
        check_count = 0;
        n = $urandom(99942);
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK({cpu, per, osc, sub, hold}, 5'b11100)
        apb(1'b0, cmpsc_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 7; i++)
        begin
            code = (i == 1) ? (8'($urandom) | 8'h04) : TAB[i];
            apb(1'b1, cmpsc_pkg::ADDR_CLK_MODE, {24'h0, code}, 1'b0, 32'h0);
            repeat (2) @(posedge clk);
            `CHK({cpu, osc, sub}, GM[i][4:2])
            apb(1'b0, cmpsc_pkg::ADDR_STATUS, 32'h0, 1'b0, {30'h0, GM[i][1:0]});
        end
        $display("mode test done");
        apb(1'b1, 8'h10 | 8'($urandom), $urandom, 1'b1, 32'h0);
        apb(1'b1, cmpsc_pkg::ADDR_STATUS, $urandom, 1'b1, 32'h0);
        code = 8'($urandom);
        if (code == cmpsc_pkg::SSC_SLEEP || code == cmpsc_pkg::SSC_STOP)
            code = 8'h33;
        apb(1'b1, cmpsc_pkg::ADDR_SLEEP_STOP, {24'h0, code}, 1'b0, 32'h0);
        apb(1'b0, cmpsc_pkg::ADDR_SLEEP_STOP, 32'h0, 1'b0, 32'h0);
        stop_pulse();
        `CHK({cpu, per}, 2'b11)
        $display("refusal test done");
        ctl = 3'($urandom);
        iflag <= 1'($urandom);
        apb(1'b1, cmpsc_pkg::ADDR_CONTROL, {29'h0, ctl}, 1'b0, 32'h0);
        apb(1'b1, cmpsc_pkg::ADDR_SLEEP_STOP, 32'h0f, 1'b0, 32'h0);
        `CHK({cpu, per, osc, hold, bitr, tmr, watch}, 7'b0111110)
        irq <= 1'b1;
        wait_cpu(n);
        `CHK({wvec, wres}, {iflag, ~iflag})
        irq <= 1'b0;
        apb(1'b0, cmpsc_pkg::ADDR_CONTROL, 32'h0, 1'b0, {29'h0, ctl});
        apb(1'b0, cmpsc_pkg::ADDR_SLEEP_STOP, 32'h0, 1'b0, 32'h0);
        $display("sleep test done");
        ctl = 3'($urandom);
        iflag <= 1'($urandom);
        apb(1'b1, cmpsc_pkg::ADDR_CONTROL, {29'h0, ctl}, 1'b0, 32'h0);
        apb(1'b1, cmpsc_pkg::ADDR_SLEEP_STOP, 32'h5a, 1'b0, 32'h0);
        apb(1'b0, cmpsc_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h10);
        stop_pulse();
        `CHK({cpu, per, osc, hold, bitr, wdt, tmr, watch}, {4'b0001, ctl[0], ctl[0], ctl[1], ctl[2]})
        src <= 6'(1 << ($urandom % 6));
        @(posedge clk);
        src <= 6'h00;
        repeat (2) @(posedge clk);
        `CHK({cpu, per, osc, hold}, 4'b0011)
        wait_cpu(n);
        `CHK(n > 400, 1'b1)
        `CHK({wvec, wres}, {iflag, ~iflag})
        $display("stop test done");
        apb(1'b1, cmpsc_pkg::ADDR_SLEEP_STOP, 32'h5a, 1'b0, 32'h0);
        stop_pulse();
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK({cpu, per, osc, sub, hold}, 5'b11100)
        apb(1'b0, cmpsc_pkg::ADDR_CONTROL, 32'h0, 1'b0, 32'h0);
        $display("reset wake test done");
        finish_test();
    end
endmodule
